/* File: design/led_cmd_port.sv */
/*
  Four-wire serial command port and command decoder of an LED matrix
  controller, with the 88x4 display RAM and a small register port.
  Assumes select, strobes and data come from another clock domain and that
  the host holds data steady for several core cycles around each strobe rise.
*/
`timescale 1ns/1ps
`default_nettype none

module led_cmd_port (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_serial_select_n,
  input  wire logic        i_write_strobe_n,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_data,
  output logic             o_data,
  output logic             o_data_oe_n,
  output logic             o_osc_enable,
  output logic             o_duty_enable,
  output logic [1:0]       o_blink_sel,
  output logic [2:0]       o_clock_mode,
  output logic             o_ext_clock_sel,
  output logic             o_osc_pin_oe_n,
  output logic             o_osc_pin_hold_low,
  output logic             o_sync_pin_oe_n,
  output logic             o_sync_pin_hold_high,
  output logic             o_com_pmos,
  output logic [3:0]       o_pwm_duty,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [31:0]      o_reg_rdata
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once the second and third stages agree

  logic [3:0] pins_w;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] lvl_r;
  logic [3:0] rise_w;
  logic [3:0] fall_w;

  assign pins_w = {i_serial_select_n, i_write_strobe_n, i_read_strobe_n, i_data};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      logic agree_w;
      assign agree_w   = (s2_r[g] == s3_r[g]);
      assign rise_w[g] = agree_w & s3_r[g] & ~lvl_r[g];
      assign fall_w[g] = agree_w & ~s3_r[g] & lvl_r[g];
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          s1_r[g]  <= led_cmd_port_pkg::PIN_IDLE[g];
          s2_r[g]  <= led_cmd_port_pkg::PIN_IDLE[g];
          s3_r[g]  <= led_cmd_port_pkg::PIN_IDLE[g];
          lvl_r[g] <= led_cmd_port_pkg::PIN_IDLE[g];
        end else begin
          s1_r[g] <= pins_w[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (agree_w) begin
            lvl_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate

  logic sel_high_w;
  logic wr_rise_w;
  logic wr_fall_w;
  logic rd_fall_w;
  logic din_w;

  // Data settles well before its strobe, so its filtered level is current
  assign sel_high_w = lvl_r[led_cmd_port_pkg::PIN_SEL];
  assign wr_rise_w  = rise_w[led_cmd_port_pkg::PIN_WR] & ~sel_high_w;
  assign wr_fall_w  = fall_w[led_cmd_port_pkg::PIN_WR] & ~sel_high_w;
  assign rd_fall_w  = fall_w[led_cmd_port_pkg::PIN_RD] & ~sel_high_w;
  assign din_w      = lvl_r[led_cmd_port_pkg::PIN_DAT];

  //////////////////////////////////////////////////////////////////////////////
  // Serial state, RAM and decoding

  led_cmd_port_pkg::state_t st_r;
  led_cmd_port_pkg::state_t tgt_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [6:0] ptr_r;
  logic [1:0] rd_bit_r;
  logic [2:0] nib_r;
  logic       rmw_sel_r;
  logic       data_r;
  logic       data_oe_n_r;
  logic [3:0] ram [led_cmd_port_pkg::RAM_DEPTH];

  logic       osc_en_r;
  logic       duty_en_r;
  logic [1:0] blink_r;
  logic [2:0] mode_r;
  logic       com_r;
  logic [3:0] pwm_r;

  logic [2:0] id_full_w;
  logic [6:0] addr_full_w;
  logic [7:0] cmd_w;
  logic       ptr_ok_w;
  logic [6:0] ptr_inc_w;
  logic [3:0] ram_rd_w;
  logic       id_done_w;
  logic       addr_done_w;
  logic       nib_done_w;
  logic       cmd_fire_w;
  logic       ram_we_w;
  logic       rd_shift_w;

  function automatic logic [6:0] next_ptr(input logic [6:0] p);
    next_ptr = (p >= led_cmd_port_pkg::RAM_LAST) ? led_cmd_port_pkg::RAM_FIRST : 7'(p + 7'h01);
  endfunction

  assign id_full_w   = {sh_r[1:0], din_w};
  assign addr_full_w = {sh_r[5:0], din_w};
  assign cmd_w       = sh_r;
  assign ptr_ok_w    = (ptr_r <= led_cmd_port_pkg::RAM_LAST);
  assign ptr_inc_w   = next_ptr(ptr_r);
  assign ram_rd_w    = ptr_ok_w ? ram[ptr_r] : 4'h0;
  assign id_done_w   = wr_rise_w && (st_r == led_cmd_port_pkg::ST_ID) && (cnt_r == led_cmd_port_pkg::ID_LAST);
  assign addr_done_w = wr_rise_w && (st_r == led_cmd_port_pkg::ST_ADDR) && (cnt_r == led_cmd_port_pkg::ADDR_LAST);
  assign nib_done_w  = wr_rise_w && ((st_r == led_cmd_port_pkg::ST_WRITE) || (st_r == led_cmd_port_pkg::ST_RMW))
                       && (cnt_r == led_cmd_port_pkg::NIB_LAST);
  assign cmd_fire_w  = wr_rise_w && (st_r == led_cmd_port_pkg::ST_CMD) && (cnt_r == led_cmd_port_pkg::CMD_LAST);
  assign ram_we_w    = nib_done_w && ptr_ok_w;
  assign rd_shift_w  = rd_fall_w && ((st_r == led_cmd_port_pkg::ST_READ) || (st_r == led_cmd_port_pkg::ST_RMW));

  // Target after the address; 101 means write or RMW as software selects
  led_cmd_port_pkg::state_t id_tgt_w;
  assign id_tgt_w = (id_full_w == led_cmd_port_pkg::ID_READ)  ? led_cmd_port_pkg::ST_READ :
                    (rmw_sel_r) ? led_cmd_port_pkg::ST_RMW : led_cmd_port_pkg::ST_WRITE;

  always_ff @(posedge i_clk) begin
    if (ram_we_w) begin
      ram[ptr_r] <= {din_w, nib_r};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r        <= led_cmd_port_pkg::ST_ID;
      tgt_r       <= led_cmd_port_pkg::ST_WRITE;
      cnt_r       <= 4'h0;
      sh_r        <= 8'h00;
      ptr_r       <= 7'h00;
      rd_bit_r    <= 2'h0;
      nib_r       <= 3'h0;
      data_r      <= 1'b0;
      data_oe_n_r <= 1'b1;
    end else if (sel_high_w) begin
      st_r        <= led_cmd_port_pkg::ST_ID;
      cnt_r       <= 4'h0;
      rd_bit_r    <= 2'h0;
      data_oe_n_r <= 1'b1;
    end else begin
      if (wr_rise_w) begin
        case (st_r)
          led_cmd_port_pkg::ST_ID: begin
            sh_r  <= {sh_r[6:0], din_w};
            cnt_r <= 4'(cnt_r + 4'h1);
            if (id_done_w) begin
              cnt_r <= 4'h0;
              if (id_full_w == led_cmd_port_pkg::ID_CMD) begin
                st_r <= led_cmd_port_pkg::ST_CMD;
              end else if ((id_full_w == led_cmd_port_pkg::ID_READ) ||
                           (id_full_w == led_cmd_port_pkg::ID_WRITE)) begin
                st_r  <= led_cmd_port_pkg::ST_ADDR;
                tgt_r <= id_tgt_w;
              end else begin
                st_r <= led_cmd_port_pkg::ST_DEAD;
              end
            end
          end
          led_cmd_port_pkg::ST_ADDR: begin
            sh_r  <= {sh_r[6:0], din_w};
            cnt_r <= 4'(cnt_r + 4'h1);
            if (addr_done_w) begin
              ptr_r <= addr_full_w;
              cnt_r <= 4'h0;
              st_r  <= tgt_r;
            end
          end
          led_cmd_port_pkg::ST_WRITE, led_cmd_port_pkg::ST_RMW: begin
            nib_r             <= {din_w, nib_r[2:1]};
            cnt_r             <= 4'(cnt_r + 4'h1);
            if (nib_done_w) begin
              cnt_r <= 4'h0;
              ptr_r <= ptr_inc_w;
            end
          end
          led_cmd_port_pkg::ST_CMD: begin
            if (cnt_r != led_cmd_port_pkg::CMD_LAST) begin
              sh_r <= {sh_r[6:0], din_w};
            end
            // Stay in command mode for back-to-back commands
            cnt_r <= cmd_fire_w ? 4'h0 : 4'(cnt_r + 4'h1);
          end
          default: begin
            cnt_r <= cnt_r;
          end
        endcase
      end
      if (rd_shift_w) begin
        data_r      <= ram_rd_w[rd_bit_r];
        data_oe_n_r <= 1'b0;
        rd_bit_r    <= 2'(rd_bit_r + 2'h1);
        if ((st_r == led_cmd_port_pkg::ST_READ) && (rd_bit_r == 2'h3)) begin
          ptr_r <= ptr_inc_w;
        end
      end
      // In RMW the host takes the line back for the replacement nibble
      if (wr_fall_w && (st_r == led_cmd_port_pkg::ST_RMW)) begin
        data_oe_n_r <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command execution

  logic is_sys_w;
  logic is_led_w;
  logic is_blink_w;
  logic is_clk_w;
  logic is_com_w;
  logic is_pwm_w;
  logic [2:0] mode_w;

  assign is_sys_w   = cmd_fire_w && (cmd_w[7:1] == led_cmd_port_pkg::CMD_SYS_HI);
  assign is_led_w   = cmd_fire_w && (cmd_w[7:1] == led_cmd_port_pkg::CMD_LED_HI);
  assign is_blink_w = cmd_fire_w && (cmd_w[7:2] == led_cmd_port_pkg::CMD_BLINK_HI);
  assign is_clk_w   = cmd_fire_w && (cmd_w[7:4] == led_cmd_port_pkg::CMD_CLK_HI);
  assign is_com_w   = cmd_fire_w && (cmd_w[7:4] == led_cmd_port_pkg::CMD_COM_HI);
  assign is_pwm_w   = cmd_fire_w && (cmd_w[7:5] == led_cmd_port_pkg::CMD_PWM_HI);
  assign mode_w     = cmd_w[3] ? {1'b1, cmd_w[2:1]} : led_cmd_port_pkg::MODE_SLAVE;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      osc_en_r  <= 1'b0;
      duty_en_r <= 1'b0;
      blink_r   <= led_cmd_port_pkg::BLINK_OFF;
      mode_r    <= led_cmd_port_pkg::MODE_DEFAULT;
      com_r     <= led_cmd_port_pkg::COM_DEFAULT;
      pwm_r     <= led_cmd_port_pkg::PWM_DEFAULT;
    end else begin
      if (is_sys_w) begin
        osc_en_r <= cmd_w[0];
        if (!cmd_w[0]) begin
          duty_en_r <= 1'b0;
        end
      end
      if (is_led_w) begin
        duty_en_r <= cmd_w[0];
      end
      if (is_blink_w) begin
        blink_r <= cmd_w[1:0];
      end
      if (is_clk_w) begin
        mode_r <= mode_w;
      end
      if (is_com_w) begin
        com_r <= cmd_w[3];
      end
      if (is_pwm_w) begin
        pwm_r <= cmd_w[3:0];
      end
    end
  end

  // Clock and sync pin control, registered so every output leaves a flop
  logic master_w;
  logic ext_w;
  logic casc_w;
  assign master_w = mode_r[led_cmd_port_pkg::MODE_MASTER_BIT];
  assign ext_w    = mode_r[led_cmd_port_pkg::MODE_EXT_BIT];
  assign casc_w   = mode_r[led_cmd_port_pkg::MODE_CASC_BIT];

  logic ext_sel_r;
  logic osc_oe_n_r;
  logic osc_low_r;
  logic sync_oe_n_r;
  logic sync_high_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_sel_r   <= 1'b0;
      osc_oe_n_r  <= 1'b0;
      osc_low_r   <= 1'b1;
      sync_oe_n_r <= 1'b0;
      sync_high_r <= 1'b1;
    end else begin
      ext_sel_r   <= ~master_w | ext_w;
      osc_oe_n_r  <= ~(master_w & ~ext_w);
      osc_low_r   <= master_w & ~ext_w & ~casc_w;
      sync_oe_n_r <= ~master_w;
      sync_high_r <= master_w & ~casc_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register port: data stands in the cycle after the read strobe

  logic [6:0]  ram_idx_r;
  logic [31:0] rdata_r;
  logic [31:0] status_w;
  logic [31:0] rsel_w;
  logic [3:0]  idx_data_w;

  assign idx_data_w = (ram_idx_r <= led_cmd_port_pkg::RAM_LAST) ? ram[ram_idx_r] : 4'h0;
  assign status_w   = {6'h00, st_r, ptr_r, pwm_r, com_r, mode_r, blink_r, duty_en_r, osc_en_r};
  assign rsel_w     = (i_reg_addr == led_cmd_port_pkg::REG_CTRL)     ? {31'h0, rmw_sel_r} :
                      (i_reg_addr == led_cmd_port_pkg::REG_STATUS)   ? status_w :
                      (i_reg_addr == led_cmd_port_pkg::REG_RAM_IDX)  ? {25'h0, ram_idx_r} :
                      (i_reg_addr == led_cmd_port_pkg::REG_RAM_DATA) ? {28'h0, idx_data_w} : 32'h0;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rmw_sel_r <= 1'b0;
      ram_idx_r <= 7'h00;
      rdata_r   <= 32'h0;
    end else begin
      rdata_r <= i_reg_rd ? rsel_w : 32'h0;
      if (i_reg_wr && (i_reg_addr == led_cmd_port_pkg::REG_CTRL)) begin
        rmw_sel_r <= i_reg_wdata[led_cmd_port_pkg::CTRL_RMW_BIT];
      end
      if (i_reg_wr && (i_reg_addr == led_cmd_port_pkg::REG_RAM_IDX)) begin
        ram_idx_r <= i_reg_wdata[6:0];
      end
    end
  end

  assign o_data               = data_r;
  assign o_data_oe_n          = data_oe_n_r;
  assign o_osc_enable         = osc_en_r;
  assign o_duty_enable        = duty_en_r;
  assign o_blink_sel          = blink_r;
  assign o_clock_mode         = mode_r;
  assign o_ext_clock_sel      = ext_sel_r;
  assign o_osc_pin_oe_n       = osc_oe_n_r;
  assign o_osc_pin_hold_low   = osc_low_r;
  assign o_sync_pin_oe_n      = sync_oe_n_r;
  assign o_sync_pin_hold_high = sync_high_r;
  assign o_com_pmos           = com_r;
  assign o_pwm_duty           = pwm_r;
  assign o_reg_rdata          = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  sel_reset_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sel_high_w |=> (st_r == led_cmd_port_pkg::ST_ID) && (cnt_r == 4'h0))
    else $error("select high did not reset the serial state");

  sel_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sel_high_w |=> o_data_oe_n)
    else $error("data line still driven with select high");

  cmd_entry_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (id_done_w && !sel_high_w && (id_full_w == led_cmd_port_pkg::ID_CMD)) |=> (st_r == led_cmd_port_pkg::ST_CMD))
    else $error("command ID did not enter command mode");

  cmd_repeat_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_fire_w && !sel_high_w) |=> (st_r == led_cmd_port_pkg::ST_CMD) && (cnt_r == 4'h0))
    else $error("command mode not kept for the next command");

  read_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rd_shift_w && !sel_high_w) |=> !o_data_oe_n && (o_data == $past(ram_rd_w[rd_bit_r])))
    else $error("read bit not driven after read strobe fall");

  ptr_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (nib_done_w && !sel_high_w && (ptr_r < led_cmd_port_pkg::RAM_LAST)) |=> (ptr_r == 7'($past(ptr_r) + 7'h01)))
    else $error("pointer did not step after a nibble");

  ptr_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (nib_done_w && !sel_high_w && (ptr_r == led_cmd_port_pkg::RAM_LAST)) |=> (ptr_r == led_cmd_port_pkg::RAM_FIRST))
    else $error("pointer did not wrap to zero");

  sys_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (is_sys_w && !sel_high_w && !cmd_w[0]) |=> !o_osc_enable && !o_duty_enable)
    else $error("system disable left oscillator or duty running");

  duty_cmd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (is_led_w && !sel_high_w) |=> (o_duty_enable == $past(cmd_w[0])))
    else $error("duty generator command not applied");

  blink_cmd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (is_blink_w && !sel_high_w) |=> (o_blink_sel == $past(cmd_w[1:0])))
    else $error("blink command not applied");

  pwm_cmd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (is_pwm_w && !sel_high_w) |=> (o_pwm_duty == $past(cmd_w[3:0])))
    else $error("duty step command not applied");

  single_pins_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_r == led_cmd_port_pkg::MODE_INT_SINGLE) ##1 (mode_r == led_cmd_port_pkg::MODE_INT_SINGLE)
    |-> !o_osc_pin_oe_n && o_osc_pin_hold_low && !o_sync_pin_oe_n && o_sync_pin_hold_high)
    else $error("single-chip master pins wrong");

  slave_pins_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_r == led_cmd_port_pkg::MODE_SLAVE) ##1 (mode_r == led_cmd_port_pkg::MODE_SLAVE)
    |-> o_osc_pin_oe_n && o_sync_pin_oe_n && o_ext_clock_sel)
    else $error("slave pins not released as inputs");

endmodule

`default_nettype wire

/* File: design/led_cmd_port_pkg.sv */
/*
  Constants, command codes, mode codes, register offsets and the state type
  of the four-wire command port of an LED matrix controller.
  Assumes a single 100 MHz core clock and a synchronous active-low reset.
*/
// Notes on behaviour
// - A transaction opens with a 3-bit ID: 110 read, 101 write or RMW, 100 command.
// - Mode ID comes first; further commands in one select period skip the 100 ID.
// - Select high drops the current mode; after select low a new ID is needed.
// - Select high disables and re-initialises the serial logic.
// - In read mode RAM bits go out on the data line at read strobe falls.
// - Mode ID, address, data and command bits are taken at write strobe rises.
// - Data transfer: seven address bits A6 first, then data D0 up to D3.
// - Successive access wraps the RAM pointer from the last location to zero.
// - RMW outputs the addressed nibble, then takes a new nibble for it.
// - Code 0000-0000 stops oscillator and duty generator; 0000-0001 starts oscillator.
// - Code 0000-0010 disables the duty generator; 0000-0011 enables it.
// - Codes 0000-10bb: blink off, fast, medium or slow whole-display flashing.
// - Code 0001-0xxx: slave, clock and sync both taken in from their pins.
// - Code 0001-101x: internal oscillator, clock and sync driven out.
// - Code 0001-110x: external clock in, sync pin held high.
// - Code 0001-111x: external clock in, sync driven out.
// - Code 0010-axxx: common drive type, a=0 N-channel, a=1 P-channel.
// - Don't-care bits, including the ninth command bit, are ignored.
// - RAM pointer increments after each four-bit nibble.
// - After reset the oscillator and duty generator are stopped.
package led_cmd_port_pkg;

  // Mode IDs
  localparam logic [2:0] ID_READ  = 3'h6;
  localparam logic [2:0] ID_WRITE = 3'h5;
  localparam logic [2:0] ID_CMD   = 3'h4;

  // Field lengths, counted from zero
  localparam logic [3:0] ID_LAST   = 4'h2;
  localparam logic [3:0] ADDR_LAST = 4'h6;
  localparam logic [3:0] NIB_LAST  = 4'h3;
  localparam logic [3:0] CMD_LAST  = 4'h8;

  // Display RAM
  localparam int         RAM_DEPTH = 88;
  localparam logic [6:0] RAM_LAST  = 7'h57;
  localparam logic [6:0] RAM_FIRST = 7'h00;

  // Command prefixes, matched against the first eight command bits
  localparam logic [6:0] CMD_SYS_HI   = 7'h00;
  localparam logic [6:0] CMD_LED_HI   = 7'h01;
  localparam logic [5:0] CMD_BLINK_HI = 6'h02;
  localparam logic [3:0] CMD_CLK_HI   = 4'h1;
  localparam logic [3:0] CMD_COM_HI   = 4'h2;
  localparam logic [2:0] CMD_PWM_HI   = 3'h5;

  // Clock source modes; bit 2 marks master, bit 1 external clock, bit 0 cascade
  localparam logic [2:0] MODE_SLAVE       = 3'h0;
  localparam logic [2:0] MODE_INT_SINGLE  = 3'h4;
  localparam logic [2:0] MODE_INT_CASCADE = 3'h5;
  localparam logic [2:0] MODE_EXT_SINGLE  = 3'h6;
  localparam logic [2:0] MODE_EXT_CASCADE = 3'h7;
  localparam int         MODE_MASTER_BIT  = 2;
  localparam int         MODE_EXT_BIT     = 1;
  localparam int         MODE_CASC_BIT    = 0;

  // Blink selections
  localparam logic [1:0] BLINK_OFF    = 2'h0;
  localparam logic [1:0] BLINK_FAST   = 2'h1;
  localparam logic [1:0] BLINK_MEDIUM = 2'h2;
  localparam logic [1:0] BLINK_SLOW   = 2'h3;

  // Reset values
  localparam logic [3:0] PWM_DEFAULT   = 4'hf;
  localparam logic [2:0] MODE_DEFAULT  = MODE_INT_SINGLE;
  localparam logic       COM_DEFAULT   = 1'b0;
  localparam logic [3:0] PIN_IDLE      = 4'he;

  // Synchroniser lanes
  localparam int PIN_SEL = 3;
  localparam int PIN_WR  = 2;
  localparam int PIN_RD  = 1;
  localparam int PIN_DAT = 0;

  // Register offsets, byte addresses
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_RAM_IDX  = 4'h8;
  localparam logic [3:0] REG_RAM_DATA = 4'hc;
  localparam int         CTRL_RMW_BIT = 0;

  typedef enum logic [6:0] {
    ST_ID    = 7'h01,
    ST_ADDR  = 7'h02,
    ST_WRITE = 7'h04,
    ST_READ  = 7'h08,
    ST_RMW   = 7'h10,
    ST_CMD   = 7'h20,
    ST_DEAD  = 7'h40
  } state_t;

endpackage

/* File: verif/host_model.sv */
/* Host side of the four-wire port: select, strobes and data.
   Assumes a 100 MHz i_clk; read strobes have a 160 ns period, write strobes 240 ns. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic i_clk,
  input  wire logic i_line,
  output var logic  o_select_n,
  output var logic  o_write_n,
  output var logic  o_read_n,
  output var logic  o_data
);
  initial begin
    o_select_n = 1'b1;
    o_write_n  = 1'b1;
    o_read_n   = 1'b1;
    o_data     = 1'b0;
  end
  ////////////////////////////////////////
  task automatic half();
    repeat (8) @(posedge i_clk);
  endtask
  task automatic open_tx();
    o_select_n <= 1'b1;
    repeat (3) half();
    o_select_n <= 1'b0;
    half();
  endtask
  // Data held long around the rise, the synchronisers need it
  task automatic bit_out(input logic b);
    o_data <= b;
    half();
    o_write_n <= 1'b0;
    half();
    o_write_n <= 1'b1;
    half();
  endtask
  task automatic id(input logic [2:0] v);
    for (int i = 2; i >= 0; i--) bit_out(v[i]);
  endtask
  task automatic addr(input logic [6:0] v);
    for (int i = 6; i >= 0; i--) bit_out(v[i]);
  endtask
  task automatic cmd(input logic [8:0] v);
    for (int i = 8; i >= 0; i--) bit_out(v[i]);
  endtask
  task automatic nib_out(input logic [3:0] v);
    for (int i = 0; i < 4; i++) bit_out(v[i]);
  endtask
  // Released line shows the inverse, so a stale bit never passes
  task automatic nib_in(output logic [3:0] v);
    o_data <= ~o_data;
    for (int i = 0; i < 4; i++) begin
      o_read_n <= 1'b0;
      half();
      o_read_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      v[i] = i_line;
      repeat (4) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
/* Self-checking bench for the command port.
   Assumes the design package and host_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        sel_n, wr_n, rd_n, h_data, data_out, oe_n, osc_en, duty_en, com;
  logic [1:0]  blink;
  logic [2:0]  mode;
  wire  [4:0]  pin_ctl;
  logic [3:0]  pwm, v, reg_addr = 4'h0;
  logic [3:0]  nib [3];
  logic [31:0] reg_wdata = 32'h0, rdata, r32;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  int          seed = 4395, n_mismatch = 0, tests_run = 0;
  wire         line = (oe_n === 1'b0) ? data_out : h_data;
  always #5 i_clk = ~i_clk;
  host_model host (.i_clk(i_clk), .i_line(line), .o_select_n(sel_n), .o_write_n(wr_n),
    .o_read_n(rd_n), .o_data(h_data));
  led_cmd_port DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_serial_select_n(sel_n),
    .i_write_strobe_n(wr_n), .i_read_strobe_n(rd_n), .i_data(line), .o_data(data_out),
    .o_data_oe_n(oe_n), .o_osc_enable(osc_en), .o_duty_enable(duty_en), .o_blink_sel(blink),
    .o_clock_mode(mode), .o_ext_clock_sel(pin_ctl[4]), .o_osc_pin_oe_n(pin_ctl[3]),
    .o_osc_pin_hold_low(pin_ctl[2]), .o_sync_pin_oe_n(pin_ctl[1]),
    .o_sync_pin_hold_high(pin_ctl[0]), .o_com_pmos(com), .o_pwm_duty(pwm),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(rdata));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pin control per clock mode: {ext clock, osc oe_n, osc low, sync oe_n, sync high}
  function automatic logic [4:0] pins_exp(input int m);
    case (m)
      4: pins_exp = 5'h05;
      5: pins_exp = 5'h00;
      6: pins_exp = 5'h19;
      7: pins_exp = 5'h18;
      default: pins_exp = 5'h1a;
    endcase
  endfunction
  task automatic reg_acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= ~w;
    @(posedge i_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 r32 = rdata;
  endtask
  task automatic final_report();
    $display("Counts: tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk(32'({osc_en, duty_en, blink, mode, com, pwm}), 32'h08f);
    chk(32'(pin_ctl), 32'(pins_exp(4)));
    reg_acc(1'b1, 4'h0, 32'h0);
    host.open_tx();
    host.id(3'h4);
    for (int k = 0; k < 8; k++) begin
      host.cmd({4'h1, 3'(k), 2'($random(seed))});
      chk(32'(mode), (k > 3) ? 32'(k) : 32'h0);
      chk(32'(pin_ctl), 32'(pins_exp(k)));
    end
    host.cmd({8'h01, 1'($random(seed))});
    host.cmd({8'h03, 1'($random(seed))});
    chk(32'({osc_en, duty_en}), 32'h3);
    for (int b = 0; b < 4; b++) begin
      host.cmd({6'h02, 2'(b), 1'($random(seed))});
      chk(32'(blink), 32'(b));
    end
    v = 4'($random(seed));
    host.cmd({3'h5, 1'($random(seed)), v, 1'($random(seed))});
    host.cmd({4'h2, 1'b1, 4'($random(seed))});
    chk(32'({com, pwm}), 32'({1'b1, v}));
    host.cmd({8'h02, 1'b1});
    chk(32'(duty_en), 32'h0);
    host.cmd({8'h03, 1'b0});
    host.cmd(9'h000);
    chk(32'({osc_en, duty_en}), 32'h0);
    host.open_tx();
    host.cmd(9'h003);
    chk(32'(osc_en), 32'h0);
    host.open_tx();
    host.id(3'h5);
    host.addr(7'h56);
    for (int i = 0; i < 3; i++) begin
      nib[i] = 4'($random(seed));
      host.nib_out(nib[i]);
    end
    host.open_tx();
    host.id(3'h6);
    host.addr(7'h56);
    for (int i = 0; i < 3; i++) begin
      host.nib_in(v);
      chk(32'(v), 32'(nib[i]));
    end
    reg_acc(1'b1, 4'h8, 32'h57);
    reg_acc(1'b0, 4'hc, 32'h0);
    chk(r32, 32'(nib[1]));
    reg_acc(1'b1, 4'h0, 32'h1);
    reg_acc(1'b0, 4'h0, 32'h0);
    chk(r32, 32'h1);
    host.open_tx();
    host.id(3'h5);
    host.addr(7'h57);
    for (int i = 1; i < 3; i++) begin
      host.nib_in(v);
      chk(32'({oe_n, v}), 32'(nib[i]));
      nib[i] = 4'($random(seed));
      host.nib_out(nib[i]);
      chk(32'(oe_n), 32'h1);
    end
    reg_acc(1'b0, 4'hc, 32'h0);
    chk(r32, 32'(nib[1]));
    reg_acc(1'b1, 4'h8, 32'h0);
    reg_acc(1'b0, 4'hc, 32'h0);
    chk(r32, 32'(nib[2]));
    reg_acc(1'b0, 4'h2, 32'h0);
    chk(r32, 32'h0);
    final_report();
  end
  // Whole run needs about 61 us; this leaves room to spare
  initial begin
    #300000;
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
